// >>> rtl/timer16_defs.vh
// Contract
// - two modes: interval compare-and-clear, or capture on input pin edges.
// - count at ffff sets overflow pending, requests if enabled, wraps to zero.
// - writing 1 to counter-clear bit zeroes the count at any time.
// - interval mode: count equals reference raises match, clears count.
// - match or capture sets pending bit; cleared only by software writing 0.
// - two-bit field picks rising, falling or both capture edges.
// - capture mode: qualifying edge copies count into data register pair.
// - capture mode keeps overflow and capture requests both active.
// - control register resets to 00: interval, stopped, interrupts disabled.
// - counter advances on prescaled ticks only while run bit is 1.
// - each request forwarded only while its own enable bit is 1.
// - overflow pending sets even when disabled; software clears by writing 0.
// - low four prescaler bits n divide clock by two to the power n; n above 12 divides by 2**12.
// - overflow on level three vector ea; match/capture vector ec.
`ifndef TIMER16_DEFS_VH
`define TIMER16_DEFS_VH
`define ADDR_CONTROL 8'he4
`define ADDR_PRESCALE 8'he5
`define ADDR_DATA_HIGH 8'he6
`define ADDR_DATA_LOW 8'he7
`define CTL_EDGE_HI 7
`define CTL_EDGE_LO 6
`define CTL_RUN 5
`define CTL_CLEAR 4
`define CTL_WRAP_EN 3
`define CTL_WRAP_PEND 2
`define CTL_MC_EN 1
`define CTL_MC_PEND 0
`define CONTROL_RESET 8'h00
`define PRESCALE_RESET 8'h00
`define DATA_RESET 16'hffff
`define DATA_HIGH_RESET 8'hff
`define DATA_LOW_RESET 8'hff
`define EDGE_RISE 2'h1
`define EDGE_FALL 2'h2
`define EDGE_BOTH 2'h3
`define VECTOR_WRAP 8'hea
`define VECTOR_MATCH 8'hec
`define PRESCALE_MAX 4'hc
`endif

// >>> rtl/timer16_match_capture.v
`timescale 1ns/1ps
`default_nettype none
`include "timer16_defs.vh"
// pin synchroniser: only the second stage reads the first, so a
// metastable first stage never reaches the edge logic
module timer16_pin_sync #(
	parameter STAGES = 3
) (
	input wire clk_sys,
	input wire rst,
	input wire pin_in,
	output wire level_now,
	output wire level_prev
);
	reg [STAGES-1:0] sync_q;
	reg [STAGES-1:0] sync_d;
	always @* begin
		sync_d = {sync_q[STAGES-2:0], pin_in};
	end
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			// low matches the idle pin, so no false edge follows reset
			sync_q <= {STAGES{1'b0}};
		end else begin
			sync_q <= sync_d;
		end
	end
	// an edge counts when the two settled stages disagree
	assign level_now = sync_q[STAGES-2];
	assign level_prev = sync_q[STAGES-1];
endmodule // timer16_pin_sync

// picks the edges that the control field asks for
module timer16_edge_pick (
	input wire [1:0] edge_sel,
	input wire level_now,
	input wire level_prev,
	output reg hit
);
	wire rise;
	wire fall;
	assign rise = level_now & ~level_prev;
	assign fall = ~level_now & level_prev;
	always @* begin
		hit = 1'b0;
		if (edge_sel == `EDGE_RISE) begin
			hit = rise;
		end else if (edge_sel == `EDGE_FALL) begin
			hit = fall;
		end else if (edge_sel == `EDGE_BOTH) begin
			hit = rise | fall;
		end
	end
endmodule // timer16_edge_pick

// power-of-two prescaler; the phase restarts with the counter so
// the first interval after a clear is exact
module timer16_prescaler #(
	parameter PRE_W = 12
) (
	input wire clk_sys,
	input wire rst,
	input wire run,
	input wire restart,
	input wire [3:0] shift_n,
	output wire tick
);
	localparam [PRE_W-1:0] STEP = {{(PRE_W-1){1'b0}}, 1'b1};
	reg [PRE_W-1:0] pre_q;
	reg [PRE_W-1:0] pre_d;
	wire [PRE_W-1:0] mask;
	// shift values above 12 saturate to the slowest rate
	assign mask = (STEP << shift_n) - STEP;
	always @* begin
		pre_d = pre_q;
		if (restart) begin
			pre_d = {PRE_W{1'b0}};
		end else if (run) begin
			pre_d = pre_q + STEP;
		end
	end
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pre_q <= {PRE_W{1'b0}};
		end else begin
			pre_q <= pre_d;
		end
	end
	// n low bits all ones: a tick every 2**n clocks, every clock at n=0
	assign tick = run && ((pre_q & mask) == mask);
endmodule // timer16_prescaler

// one byte of the reference/capture pair; a capture wins over a
// same-cycle software write so the measured value is never torn
module timer16_data_byte #(
	parameter [7:0] RESET_VAL = 8'hff
) (
	input wire clk_sys,
	input wire rst,
	input wire load,
	input wire [7:0] load_val,
	input wire wr,
	input wire [7:0] wdata,
	output reg [7:0] value_q
);
	reg [7:0] value_d;
	always @* begin
		value_d = value_q;
		if (load) begin
			value_d = load_val;
		end else if (wr) begin
			value_d = wdata;
		end
	end
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			value_q <= RESET_VAL;
		end else begin
			value_q <= value_d;
		end
	end
endmodule // timer16_data_byte

module timer16_match_capture #(
	parameter WIDTH = 16
) (
	input wire clk_sys,
	input wire rst,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	output reg [7:0] reg_rdata,
	input wire capture_input_pin,
	output reg wrap_interrupt,
	output reg match_capture_interrupt,
	output reg [7:0] wrap_vector,
	output reg [7:0] match_vector
);
	reg [7:0] timer_control_q;
	reg [7:0] ctl_d;
	reg [7:0] timer_prescale_select_q;
	reg [7:0] prescale_d;
	reg [WIDTH-1:0] count_q;
	reg [WIDTH-1:0] count_d;
	reg [7:0] rdata_d;
	reg wrap_irq_d;
	reg mc_irq_d;
	wire [WIDTH-1:0] ref_q;
	wire [7:0] ref_high;
	wire [7:0] ref_low;
	wire wr_ctl;
	wire wr_ps;
	wire wr_hi;
	wire wr_lo;
	wire count_clear;
	wire run;
	wire [1:0] edge_sel;
	wire capture_mode;
	wire tick;
	wire pin_now;
	wire pin_prev;
	wire edge_hit;
	wire cap_ev;
	wire wrap_ev;
	wire match_ev;
	wire mc_ev;

	// register decode
	assign wr_ctl = reg_wr && (reg_addr == `ADDR_CONTROL);
	assign wr_ps = reg_wr && (reg_addr == `ADDR_PRESCALE);
	assign wr_hi = reg_wr && (reg_addr == `ADDR_DATA_HIGH);
	assign wr_lo = reg_wr && (reg_addr == `ADDR_DATA_LOW);
	assign count_clear = wr_ctl && reg_wdata[`CTL_CLEAR];
	assign run = timer_control_q[`CTL_RUN];
	assign edge_sel = {timer_control_q[`CTL_EDGE_HI],
		timer_control_q[`CTL_EDGE_LO]};
	// a zero edge field means interval mode
	assign capture_mode = (edge_sel != 2'h0);

	timer16_prescaler #(
		.PRE_W(12)
	) u_timer16_prescaler (
		.clk_sys(clk_sys),
		.rst(rst),
		.run(run),
		.restart(count_clear),
		.shift_n(timer_prescale_select_q[3:0]),
		.tick(tick)
	);

	timer16_pin_sync #(
		.STAGES(3)
	) u_timer16_pin_sync (
		.clk_sys(clk_sys),
		.rst(rst),
		.pin_in(capture_input_pin),
		.level_now(pin_now),
		.level_prev(pin_prev)
	);

	timer16_edge_pick u_timer16_edge_pick (
		.edge_sel(edge_sel),
		.level_now(pin_now),
		.level_prev(pin_prev),
		.hit(edge_hit)
	);

	assign cap_ev = capture_mode && edge_hit;
	assign wrap_ev = tick && (count_q == {WIDTH{1'b1}});
	// the comparator is idle in capture mode so a capture is kept
	assign match_ev = tick && !capture_mode && (count_q == ref_q);
	assign mc_ev = match_ev || cap_ev;

	// control register: software writes, hardware sets pending bits
	always @* begin
		ctl_d = timer_control_q;
		if (wr_ctl) begin
			ctl_d = reg_wdata;
			// the clear bit is a strobe and always reads back 0
			ctl_d[`CTL_CLEAR] = 1'b0;
			// writing 1 leaves a pending bit as it is; only 0 clears
			ctl_d[`CTL_WRAP_PEND] = timer_control_q[`CTL_WRAP_PEND] &
				reg_wdata[`CTL_WRAP_PEND];
			ctl_d[`CTL_MC_PEND] = timer_control_q[`CTL_MC_PEND] &
				reg_wdata[`CTL_MC_PEND];
		end
		// set wins over a same-cycle software clear, so no event is lost
		if (wrap_ev) begin
			ctl_d[`CTL_WRAP_PEND] = 1'b1;
		end
		if (mc_ev) begin
			ctl_d[`CTL_MC_PEND] = 1'b1;
		end
	end
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			timer_control_q <= `CONTROL_RESET;
		end else begin
			timer_control_q <= ctl_d;
		end
	end

	// prescale select register
	always @* begin
		prescale_d = timer_prescale_select_q;
		if (wr_ps) begin
			prescale_d = reg_wdata;
		end
	end
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			timer_prescale_select_q <= `PRESCALE_RESET;
		end else begin
			timer_prescale_select_q <= prescale_d;
		end
	end

	// reference and capture data share one register pair
	timer16_data_byte #(
		.RESET_VAL(`DATA_HIGH_RESET)
	) u_data_high (
		.clk_sys(clk_sys),
		.rst(rst),
		.load(cap_ev),
		.load_val(count_q[15:8]),
		.wr(wr_hi),
		.wdata(reg_wdata),
		.value_q(ref_high)
	);
	timer16_data_byte #(
		.RESET_VAL(`DATA_LOW_RESET)
	) u_data_low (
		.clk_sys(clk_sys),
		.rst(rst),
		.load(cap_ev),
		.load_val(count_q[7:0]),
		.wr(wr_lo),
		.wdata(reg_wdata),
		.value_q(ref_low)
	);
	assign ref_q = {ref_high, ref_low};

	// up counter; a capture leaves it running untouched
	always @* begin
		count_d = count_q;
		if (count_clear) begin
			count_d = {WIDTH{1'b0}};
		end else if (wrap_ev) begin
			count_d = {WIDTH{1'b0}};
		end else if (match_ev) begin
			count_d = {WIDTH{1'b0}};
		end else if (tick) begin
			count_d = count_q + {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			count_q <= {WIDTH{1'b0}};
		end else begin
			count_q <= count_d;
		end
	end

	// requests follow the next pending and enable bits, one flop late
	always @* begin
		wrap_irq_d = ctl_d[`CTL_WRAP_EN] && ctl_d[`CTL_WRAP_PEND];
		mc_irq_d = ctl_d[`CTL_MC_EN] && ctl_d[`CTL_MC_PEND];
	end
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wrap_interrupt <= 1'b0;
			match_capture_interrupt <= 1'b0;
		end else begin
			wrap_interrupt <= wrap_irq_d;
			match_capture_interrupt <= mc_irq_d;
		end
	end

	// fixed vector codes on level three, held in flops like every output
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wrap_vector <= `VECTOR_WRAP;
			match_vector <= `VECTOR_MATCH;
		end else begin
			wrap_vector <= `VECTOR_WRAP;
			match_vector <= `VECTOR_MATCH;
		end
	end

	// read mux shows the control value taken at this edge; prescale and data as held before it
	always @* begin
		rdata_d = 8'h00;
		if (reg_addr == `ADDR_CONTROL) begin
			rdata_d = ctl_d;
		end else if (reg_addr == `ADDR_PRESCALE) begin
			rdata_d = timer_prescale_select_q;
		end else if (reg_addr == `ADDR_DATA_HIGH) begin
			rdata_d = ref_q[15:8];
		end else if (reg_addr == `ADDR_DATA_LOW) begin
			rdata_d = ref_q[7:0];
		end
	end
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= rdata_d;
		end
	end
endmodule // timer16_match_capture
`default_nettype wire

// >>> dv/timer16_sva.sv
`timescale 1ns/1ps
`default_nettype none
module timer16_sva (
	input wire logic clk_sys, rst, reg_wr, capture_input_pin,
	input wire logic wrap_interrupt, match_capture_interrupt,
	input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
	input wire logic [7:0] wrap_vector, match_vector
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence ctl_wr;
		reg_wr && reg_addr == 8'he4;
	endsequence
	AST_VEC_W: assert property (wrap_vector == 8'hea)
		else $error("wrap vector");
	AST_VEC_M: assert property (match_vector == 8'hec)
		else $error("match vector");
	AST_MC_HOLD: assert property (match_capture_interrupt && !reg_wr |=>
		match_capture_interrupt) else $error("mc dropped");
	AST_WR_HOLD: assert property (wrap_interrupt && !reg_wr |=>
		wrap_interrupt) else $error("wrap dropped");
	AST_MC_OFF: assert property (ctl_wr ##0 !reg_wdata[1] |-> ##[1:2]
		!match_capture_interrupt) else $error("mc not masked");
	AST_WR_OFF: assert property (ctl_wr ##0 !reg_wdata[3] |-> ##[1:2]
		!wrap_interrupt) else $error("wrap not masked");
	AST_CLR_RD: assert property (reg_addr == 8'he4 |=> !reg_rdata[4])
		else $error("clear bit read");
	AST_RUN_RD: assert property (ctl_wr ##1 (reg_addr == 8'he4 && !reg_wr)
		|=> reg_rdata[5] == $past(reg_wdata[5], 2)) else $error("run bit");
endmodule // timer16_sva
bind timer16_match_capture timer16_sva u_sva (.clk_sys, .rst, .reg_wr,
	.capture_input_pin, .wrap_interrupt, .match_capture_interrupt,
	.reg_addr, .reg_wdata, .reg_rdata, .wrap_vector, .match_vector);
`default_nettype wire

// >>> dv/cap_driver.sv
`timescale 1ns/1ps
`default_nettype none
module cap_driver (
	input wire logic clk_sys,
	output logic pin
);
	// pin is a configured input: edges move only off the sampling edge
	initial pin = 1'b0;
	task automatic toggle;
		@(negedge clk_sys) pin = ~pin;
	endtask
endmodule // cap_driver
`default_nettype wire

// >>> dv/timer16_match_capture_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module timer16_match_capture_tb_top;
	logic clk_sys = 0, rst = 1, reg_wr = 0, pin, w_irq, m_irq;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	int n_fail = 0, n_checks = 0;
	initial forever #2.5 clk_sys = ~clk_sys;
	cap_driver u_cap_driver (.clk_sys(clk_sys), .pin(pin));
	timer16_match_capture u_timer16_match_capture (.clk_sys(clk_sys),
		.rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rdata(reg_rdata), .capture_input_pin(pin), .wrap_interrupt(w_irq),
		.match_capture_interrupt(m_irq), .wrap_vector(), .match_vector());
	task automatic chk(logic [7:0] got, logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(negedge clk_sys) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
		@(negedge clk_sys) reg_wr = 1'b0;
	endtask
	task automatic rd_chk(logic [7:0] a, logic [7:0] m, logic [7:0] e);
		@(negedge clk_sys) reg_addr = a;
		@(negedge clk_sys) chk(reg_rdata & m, e);
	endtask
	task automatic t_reset;
		rd_chk(8'he4, 8'hff, 8'h00);
		rd_chk(8'he5, 8'hff, 8'h00);
	endtask
	task automatic t_match;
		wr(8'he6, 8'h00);
		wr(8'he7, 8'h05);
		wr(8'he4, 8'h32);
		repeat (9) if (!m_irq) @(negedge clk_sys);
		chk({7'h00, m_irq}, 8'h01);
		rd_chk(8'he4, 8'h01, 8'h01);
		// stop the counter too, so no later match can hide the clear
		wr(8'he4, 8'h02);
		repeat (10) @(negedge clk_sys);
		chk({7'h00, m_irq}, 8'h00);
	endtask
	task automatic t_presc;
		wr(8'he5, 8'h02);
		wr(8'he6, 8'h00);
		wr(8'he7, 8'h03);
		wr(8'he4, 8'h32);
		// divide by four: the fourth tick after the clear is the match
		repeat (15) @(negedge clk_sys);
		chk({7'h00, m_irq}, 8'h00);
		@(negedge clk_sys);
		chk({7'h00, m_irq}, 8'h01);
		wr(8'he4, 8'h02);
		wr(8'he5, 8'h00);
	endtask
	task automatic t_cap_wrap;
		wr(8'he4, 8'h78);
		u_cap_driver.toggle();
		repeat (6) @(negedge clk_sys);
		rd_chk(8'he4, 8'h05, 8'h01);
		rd_chk(8'he6, 8'hff, 8'h00);
		rd_chk(8'he7, 8'hff, 8'h03);
		repeat (70000) if (!w_irq) @(negedge clk_sys);
		chk({7'h00, w_irq}, 8'h01);
		rd_chk(8'he4, 8'h04, 8'h04);
		wr(8'he4, 8'hb0);
		u_cap_driver.toggle();
		repeat (6) @(negedge clk_sys);
		rd_chk(8'he4, 8'h01, 8'h01);
		rd_chk(8'he7, 8'hff, 8'h03);
	endtask
	task automatic test_done;
		if (n_fail == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (20) @(negedge clk_sys);
		rst = 1'b0;
		t_reset();
		t_match();
		t_presc();
		t_cap_wrap();
		test_done();
	end
	initial begin
		#1000000;
		n_fail++;
		test_done();
	end
endmodule // timer16_match_capture_tb_top
`default_nettype wire
